// ---- verilog/ahlm_axis.sv ----
/*
 contents: one axis of sensor-driven sequencing (leave origin, origin search, limit
 feeds) with an AHB-Lite register slave, limit filter and deviation clear output.
 assumes: synchronous sensor inputs on hclk; pulse rate fixed by PULSE_HALF.
*/
// Local design decisions: the address map and register access over AHB-Lite.
// Overview of operation
// - mode code 12h leaves origin forward, 1Ah leaves origin backward.
// - leave-origin mode pulses while origin sensor active, stops once off it.
// - leave-origin start with origin sensor inactive stops normally, no pulse.
// - origin sensor sampled at each pulse, so at least one pulse before stop.
// - mode code 15h searches origin forward, 1Dh backward.
// - origin search stops normally when origin sensor turns active.
// - origin search starting on origin first retreats, then returns to origin.
// - limit hit during search: reverse return, retreat, then forward return.
// - retreat repeats target_position pulse moves; host loads 1 to 134217727.
// - codes 20h, 28h feed to limit; 22h, 2Ah leave a limit.
// - polarity pin low means active-high limits, high means active-low.
// - stop method bit 3: 0 stops at once, 1 lets a feed-to-limit stop, or an origin search stop with the forward limit active, run briefly on, then stops.
// - sub status bit 12 shows plus limit, bit 13 minus limit.
// - filter bit 26 set ignores limit pulses shorter than about 4 us.
// - feed-to-limit start with limit already active stops, no pulses.
// - feed-to-limit runs until end or soft limit turns active.
// - leave-limit start with both limits inactive stops, no pulses.
// - leave-limit runs until end and soft limits both inactive.
// - limit-based return with bit 10 and immediate stop pulses clear at limit.
// - automatic clear emits clear pulse where origin return stops.
// - bit 11 enables the clear pulse on origin return completion.
`default_nettype none

module ahlm_axis
    import ahlm_pkg::*;
#(
    parameter int FILTER_CYCLES = FILTER_CYC,
    parameter int DECEL_PULSES  = 4
)(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        origin_sensor,
    input  wire logic        end_limit_plus,
    input  wire logic        end_limit_minus,
    input  wire logic        limit_polarity,
    input  wire logic        soft_limit_plus,
    input  wire logic        soft_limit_minus,
    output logic             pulse_out,
    output logic             dir_out,
    output logic             deviation_clear_output
);
    import ahlm_pkg::*;

    // refuse widths that the 16-bit filter and 8-bit decel counters cannot hold
    if (FILTER_CYCLES < 1 || FILTER_CYCLES > 65535 || DECEL_PULSES < 1 || DECEL_PULSES > 255)
    begin : g_bad_param
        $error("ahlm_axis: parameter out of range");
    end

    typedef struct packed {
        logic [31:0]         env;
        logic [7:0]          mode;
        logic [TARGET_W-1:0] target;
        logic [31:0]         posn;
        logic                ph_wr;
        logic [7:0]          ph_addr;
        logic [31:0]         rdata;
        ahlm_state_t         st;
        logic                dir;          // 1 = positive
        logic                pulse;
        logic [2:0]          half_cnt;
        logic [TARGET_W-1:0] move_cnt;
        logic [7:0]          decel_cnt;
        logic                decel;
        logic [15:0]         flt_cnt_p;
        logic [15:0]         flt_cnt_m;
        logic                lim_p;
        logic                lim_m;
        logic [4:0]          clr_cnt;
        logic                clr;
        logic                pout;         // registered step output
    } ahlm_regs_t;

    ahlm_regs_t r_q;
    ahlm_regs_t r_d;

    logic raw_p;
    logic raw_m;
    logic fwd_lim;
    logic rev_lim;
    logic pulse_tick;
    logic start_cmd;
    logic stop_cmd;
    logic decel_sel;

    // polarity pin low keeps inputs as-is, high inverts them
    assign raw_p     = end_limit_plus ^ limit_polarity;
    assign raw_m     = end_limit_minus ^ limit_polarity;
    assign decel_sel = r_q.env[ENV_STOP_DECEL];
    assign fwd_lim   = r_q.dir ? (r_q.lim_p | soft_limit_plus) : (r_q.lim_m | soft_limit_minus);
    assign rev_lim   = r_q.dir ? (r_q.lim_m | soft_limit_minus) : (r_q.lim_p | soft_limit_plus);
    assign pulse_tick = (r_q.half_cnt == 3'(PULSE_HALF - 1)) && r_q.pulse;
    assign start_cmd = r_q.ph_wr && r_q.ph_addr == OFS_CMD && r_q.st == AHLM_IDLE
                       && (hwdata[7:0] == CMD_START_CONST_A || hwdata[7:0] == CMD_START_CONST_B);
    assign stop_cmd  = r_q.ph_wr && r_q.ph_addr == OFS_CMD && hwdata[7:0] == CMD_STOP;

    // next-state logic for bus, filter, sequencer and clear output
    always_comb
    begin
        r_d           = r_q;
        // bus address phase capture
        r_d.ph_wr   = hsel && hready && htrans[1] && hwrite;
        if (hsel && hready && htrans[1])
            r_d.ph_addr = haddr[7:0];
        // write data phase
        if (r_q.ph_wr)
        begin
            case (r_q.ph_addr)
                OFS_ENV1:   r_d.env    = hwdata;
                OFS_MODE:   r_d.mode   = hwdata[7:0];
                OFS_TARGET: r_d.target = hwdata[TARGET_W-1:0];
                default:    ;
            endcase
        end
        // read data, registered one cycle after the address phase
        r_d.rdata = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite)
        begin
            case (haddr[7:0])
                OFS_MODE:   r_d.rdata = {24'h00_0000, r_q.mode};
                OFS_TARGET: r_d.rdata = {4'h0, r_q.target};
                OFS_SUBSTS: r_d.rdata = {16'h0000, 2'b00, r_q.lim_m, r_q.lim_p,
                                         11'h000, r_q.st != AHLM_IDLE};
                OFS_POSN:   r_d.rdata = r_q.posn;
                default:    r_d.rdata = 32'h0000_0000;
            endcase
        end

        // limit noise filter: level must hold FILTER_CYCLES before it is accepted
        if (!r_q.env[ENV_FILTER] || raw_p == r_q.lim_p)
        begin
            r_d.flt_cnt_p = 16'h0000;
            r_d.lim_p     = raw_p;
        end
        else if (r_q.flt_cnt_p == 16'(FILTER_CYCLES - 1))
            r_d.lim_p = raw_p;
        else
            r_d.flt_cnt_p = r_q.flt_cnt_p + 16'h0001;
        if (!r_q.env[ENV_FILTER] || raw_m == r_q.lim_m)
        begin
            r_d.flt_cnt_m = 16'h0000;
            r_d.lim_m     = raw_m;
        end
        else if (r_q.flt_cnt_m == 16'(FILTER_CYCLES - 1))
            r_d.lim_m = raw_m;
        else
            r_d.flt_cnt_m = r_q.flt_cnt_m + 16'h0001;

        // pulse generator: runs while pulse is set
        if (r_q.pulse)
        begin
            r_d.half_cnt = r_q.half_cnt + 3'h1;
            if (pulse_tick)
            begin
                r_d.half_cnt = 3'h0;
            end
        end

        // deviation clear pulse width timer
        if (r_q.clr_cnt != 5'h00)
            r_d.clr_cnt = r_q.clr_cnt - 5'h01;
        r_d.clr = r_d.clr_cnt != 5'h00;

        // sequencer
        case (r_q.st)
            AHLM_IDLE:
            begin
                r_d.pulse = 1'b0;
                r_d.decel = 1'b0;
                if (start_cmd)
                begin
                    r_d.half_cnt = 3'h0;
                    r_d.pulse    = 1'b1;
                    case (r_q.mode)
                        MODE_LEAVE_ORG_P, MODE_LEAVE_ORG_N:
                        begin
                            r_d.dir = r_q.mode == MODE_LEAVE_ORG_P;
                            r_d.st  = AHLM_LEAVE_ORG;
                            if (!origin_sensor)
                            begin
                                r_d.pulse     = 1'b0;
                                r_d.st        = AHLM_IDLE;
                            end
                        end
                        MODE_TO_LIM_P, MODE_TO_LIM_N:
                        begin
                            r_d.dir = r_q.mode == MODE_TO_LIM_P;
                            r_d.st  = AHLM_TO_LIM;
                            if (r_q.mode == MODE_TO_LIM_P ? (r_q.lim_p | soft_limit_plus)
                                                          : (r_q.lim_m | soft_limit_minus))
                            begin
                                r_d.pulse = 1'b0;
                                r_d.st    = AHLM_IDLE;
                            end
                        end
                        MODE_OFF_LIM_P, MODE_OFF_LIM_N:
                        begin
                            r_d.dir = r_q.mode == MODE_OFF_LIM_P;
                            r_d.st  = AHLM_OFF_LIM;
                            if (!(r_q.mode == MODE_OFF_LIM_P ? (r_q.lim_m | soft_limit_minus)
                                                             : (r_q.lim_p | soft_limit_plus)))
                            begin
                                r_d.pulse = 1'b0;
                                r_d.st    = AHLM_IDLE;
                            end
                        end
                        MODE_SEARCH_P, MODE_SEARCH_N:
                        begin
                            r_d.dir      = r_q.mode == MODE_SEARCH_P;
                            r_d.move_cnt = r_q.target;
                            r_d.st       = origin_sensor ? AHLM_SRCH_OFF_ORG
                                                         : AHLM_SRCH_FWD;
                        end
                        default:
                        begin
                            r_d.pulse = 1'b0;
                            r_d.st    = AHLM_IDLE;
                        end
                    endcase
                end
            end
            // sample origin at each pulse end, one pulse minimum
            AHLM_LEAVE_ORG:
                if (pulse_tick && !origin_sensor)
                    r_d.st = AHLM_IDLE;
            AHLM_TO_LIM:
                if (fwd_lim)
                    r_d.st = AHLM_IDLE;
            AHLM_OFF_LIM:
                if (pulse_tick && !rev_lim)
                    r_d.st = AHLM_IDLE;
            AHLM_SRCH_FWD:
                if (origin_sensor)
                begin
                    r_d.st  = AHLM_IDLE;
                    r_d.clr_cnt = r_q.env[ENV_HOME_CLR] ? 5'(CLR_CYC) : 5'h00;
                end
                else if (fwd_lim)
                begin
                    r_d.dir = !r_q.dir;
                    r_d.st  = AHLM_SRCH_RET;
                    if (r_q.env[ENV_LIM_CLR_EN] && !decel_sel)
                        r_d.clr_cnt = 5'(CLR_CYC);
                end
            // reverse origin return, type 0000: run until origin seen
            AHLM_SRCH_RET:
                if (origin_sensor)
                begin
                    r_d.move_cnt = r_q.target;
                    r_d.st       = AHLM_SRCH_BACKOUT;
                end
            // positioning retreat in the reversed direction
            AHLM_SRCH_BACKOUT:
                if (pulse_tick)
                begin
                    if (r_q.move_cnt > TARGET_W'(1))
                        r_d.move_cnt = r_q.move_cnt - TARGET_W'(1);
                    else if (origin_sensor)
                        r_d.move_cnt = r_q.target;
                    else
                    begin
                        r_d.dir = !r_q.dir;
                        r_d.st  = AHLM_SRCH_HOME;
                    end
                end
            // retreat backward off origin at start, then return forward
            AHLM_SRCH_OFF_ORG:
            begin
                r_d.dir = r_q.mode != MODE_SEARCH_P;
                if (pulse_tick)
                begin
                    if (r_q.move_cnt > TARGET_W'(1))
                        r_d.move_cnt = r_q.move_cnt - TARGET_W'(1);
                    else if (origin_sensor)
                        r_d.move_cnt = r_q.target;
                    else
                    begin
                        r_d.dir = r_q.mode == MODE_SEARCH_P;
                        r_d.st  = AHLM_SRCH_HOME;
                    end
                end
            end
            AHLM_SRCH_HOME:
                if (origin_sensor)
                begin
                    r_d.st      = AHLM_IDLE;
                    r_d.clr_cnt = r_q.env[ENV_HOME_CLR] ? 5'(CLR_CYC) : 5'h00;
                end
            default:
                r_d.st = AHLM_IDLE;
        endcase

        // deceleration stop keeps pulse on two cycles longer (idle clears decel), immediate stop halts at once
        if (r_q.st != AHLM_IDLE && r_d.st == AHLM_IDLE && r_q.st != AHLM_LEAVE_ORG
            && r_q.st != AHLM_OFF_LIM && decel_sel && fwd_lim)
        begin
            r_d.decel     = 1'b1;
            r_d.decel_cnt = 8'(DECEL_PULSES);
        end
        if (r_d.st == AHLM_IDLE && !r_d.decel)
            r_d.pulse = 1'b0;
        if (r_q.decel)
        begin
            r_d.pulse = 1'b1;
            if (pulse_tick)
            begin
                r_d.decel_cnt = r_q.decel_cnt - 8'h01;
                if (r_q.decel_cnt == 8'h01)
                begin
                    r_d.decel = 1'b0;
                    r_d.pulse = 1'b0;
                end
            end
        end
        if (stop_cmd)
        begin
            r_d.st    = AHLM_IDLE;
            r_d.pulse = 1'b0;
            r_d.decel = 1'b0;
        end
        // step output from a flop; position counts every rising step, even a cut one
        r_d.pout = r_d.pulse && !r_d.half_cnt[2] && r_d.half_cnt != 3'h0;
        if (r_d.pout && !r_q.pout)
            r_d.posn = r_d.dir ? r_q.posn + 32'h1 : r_q.posn - 32'h1;
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r_q     <= '0;
            r_q.env <= ENV1_RESET;
            r_q.st  <= AHLM_IDLE;
        end
        else
            r_q <= r_d;
    end

    assign hrdata                 = r_q.rdata;
    assign hreadyout              = 1'b1;
    assign hresp                  = 1'b0;
    assign pulse_out              = r_q.pout;
    assign dir_out                = r_q.dir;
    assign deviation_clear_output = r_q.clr;

    // leave-origin start with sensor off never leaves idle
    property p_leave_org_none;
        @(posedge hclk) disable iff (!hresetn)
        (start_cmd && !origin_sensor && (r_q.mode == MODE_LEAVE_ORG_P
            || r_q.mode == MODE_LEAVE_ORG_N)) |=> (r_q.st == AHLM_IDLE && !r_q.pulse);
    endproperty
    a_leave_org_none: assert property (p_leave_org_none) else $error("leave origin pulsed");

    property p_to_lim_none;
        @(posedge hclk) disable iff (!hresetn)
        (start_cmd && r_q.mode == MODE_TO_LIM_P && (r_q.lim_p | soft_limit_plus))
            |=> r_q.st == AHLM_IDLE;
    endproperty
    a_to_lim_none: assert property (p_to_lim_none) else $error("feed at limit started");

    property p_to_lim_stop;
        @(posedge hclk) disable iff (!hresetn)
        (r_q.st == AHLM_TO_LIM && fwd_lim && !stop_cmd) |=> r_q.st == AHLM_IDLE;
    endproperty
    a_to_lim_stop: assert property (p_to_lim_stop) else $error("feed passed limit");

    property p_off_lim_none;
        @(posedge hclk) disable iff (!hresetn)
        (start_cmd && r_q.mode == MODE_OFF_LIM_N && !(r_q.lim_p | soft_limit_plus))
            |=> !r_q.pulse;
    endproperty
    a_off_lim_none: assert property (p_off_lim_none) else $error("leave limit pulsed");

    property p_plus_status;
        @(posedge hclk) disable iff (!hresetn)
        (!r_q.env[ENV_FILTER] && !$past(r_q.env[ENV_FILTER])) |-> r_q.lim_p == $past(raw_p);
    endproperty
    a_plus_status: assert property (p_plus_status) else $error("plus limit status wrong");

    property p_search_home;
        @(posedge hclk) disable iff (!hresetn)
        (r_q.st == AHLM_SRCH_FWD && origin_sensor && r_q.env[ENV_HOME_CLR] && !stop_cmd)
            |=> ##1 deviation_clear_output [*8];
    endproperty
    a_search_home: assert property (p_search_home) else $error("no clear at home");

    property p_no_clr;
        @(posedge hclk) disable iff (!hresetn)
        (r_q.st == AHLM_SRCH_HOME && origin_sensor && !r_q.env[ENV_HOME_CLR]
            && r_q.clr_cnt == 5'h00) |=> ##1 !deviation_clear_output;
    endproperty
    a_no_clr: assert property (p_no_clr) else $error("clear without enable");

    property p_filter_short;
        @(posedge hclk) disable iff (!hresetn)
        (r_q.env[ENV_FILTER] && $rose(raw_p) && !r_q.lim_p) ##1 !raw_p |-> !r_q.lim_p;
    endproperty
    a_filter_short: assert property (p_filter_short) else $error("short glitch passed");
endmodule : ahlm_axis

`default_nettype wire

// ---- include/ahlm_pkg.sv ----
/*
 contents: constants, register map and types for the axis home and limit mode block.
 assumes: a single 125 MHz clock (hclk) and an AHB-Lite register bus.
*/
`default_nettype none

package ahlm_pkg;
    // clock and timing
    localparam int          CLK_MHZ        = 125;
    localparam int          FILTER_NS      = 4000;               // limit noise filter span
    localparam int          FILTER_CYC     = FILTER_NS * CLK_MHZ / 1000;

    // register byte offsets (block-local choices)
    localparam logic [7:0]  OFS_ENV1       = 8'h00;              // environment_setting_one
    localparam logic [7:0]  OFS_MODE       = 8'h04;              // operation_mode_code
    localparam logic [7:0]  OFS_TARGET     = 8'h08;              // target_position
    localparam logic [7:0]  OFS_CMD        = 8'h0c;              // start/stop command
    localparam logic [7:0]  OFS_SUBSTS     = 8'h10;              // sub_status_word
    localparam logic [7:0]  OFS_POSN       = 8'h14;              // mechanical_position_counter

    // environment_setting_one fields
    localparam int          ENV_STOP_DECEL = 3;
    localparam int          ENV_LIM_CLR_EN = 10;
    localparam int          ENV_HOME_CLR   = 11;
    localparam int          ENV_FILTER     = 26;
    localparam logic [31:0] ENV1_RESET     = 32'h0000_0000;

    // sub status fields
    localparam int          SST_PLUS_LIM   = 12;
    localparam int          SST_MINUS_LIM  = 13;
    localparam int          SST_BUSY       = 0;

    // operation mode codes
    localparam logic [7:0]  MODE_LEAVE_ORG_P = 8'h12;
    localparam logic [7:0]  MODE_LEAVE_ORG_N = 8'h1a;
    localparam logic [7:0]  MODE_SEARCH_P    = 8'h15;
    localparam logic [7:0]  MODE_SEARCH_N    = 8'h1d;
    localparam logic [7:0]  MODE_TO_LIM_P    = 8'h20;
    localparam logic [7:0]  MODE_TO_LIM_N    = 8'h28;
    localparam logic [7:0]  MODE_OFF_LIM_P   = 8'h22;
    localparam logic [7:0]  MODE_OFF_LIM_N   = 8'h2a;

    // commands
    localparam logic [7:0]  CMD_START_CONST_A = 8'h50;
    localparam logic [7:0]  CMD_START_CONST_B = 8'h51;
    localparam logic [7:0]  CMD_STOP          = 8'h49;

    localparam int          TARGET_MAX   = 134217727;
    localparam int          TARGET_W     = 28;
    localparam int          PULSE_HALF   = 4;                    // cycles per whole pulse period
    localparam int          CLR_CYC      = 16;                   // deviation clear timer load, one cycle more than pulse width

    typedef enum logic [3:0] {
        AHLM_IDLE,
        AHLM_LEAVE_ORG,
        AHLM_TO_LIM,
        AHLM_OFF_LIM,
        AHLM_SRCH_FWD,
        AHLM_SRCH_RET,
        AHLM_SRCH_BACKOUT,
        AHLM_SRCH_OFF_ORG,
        AHLM_SRCH_HOME
    } ahlm_state_t;
endpackage : ahlm_pkg

`default_nettype wire

// ---- sim/ahlm_drive_model.sv ----
/*
 holds: motor driver model that follows step pulses and drives the sensors.
 assumes: pulse_out and dir_out of the axis block, sampled on hclk.
*/
`default_nettype none
module ahlm_drive_model (
    input  wire logic hclk,
    input  wire logic pulse_out,
    input  wire logic dir_out,
    input  wire logic limit_polarity,
    output logic      origin_sensor,
    output logic      end_limit_plus,
    output logic      end_limit_minus,
    output var int    pos
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pulse_q = 1'b0;
    initial pos = 0;
    // one step per rising pulse edge
    always @(posedge hclk)
    begin
        pulse_q <= pulse_out;
        if (pulse_out && !pulse_q)
            pos <= dir_out ? pos + 1 : pos - 1;
    end
    // origin over 0..3, limits at +/-40, pins inverted when polarity high
    assign origin_sensor   = (pos >= 0) && (pos <= 3);
    assign end_limit_plus  = (pos >= 40) ^ limit_polarity;
    assign end_limit_minus = (pos <= -40) ^ limit_polarity;
endmodule : ahlm_drive_model
`default_nettype wire

// ---- sim/testbench.sv ----
/*
 holds: self-checking bench for the axis block with the drive model.
 assumes: zero-wait AHB-Lite slave, hready fed from hreadyout.
*/
`default_nettype none
module testbench;
    import ahlm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, limit_polarity = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, origin_sensor, end_limit_plus, end_limit_minus;
    logic soft_limit_plus = 0, soft_limit_minus = 0;
    logic pulse_out, dir_out, deviation_clear_output;
    int pos, n_fail = 0, comparisons = 0, n_clr = 0;
    ahlm_axis #(.FILTER_CYCLES(4)) i_ahlm_axis (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .origin_sensor, .end_limit_plus, .end_limit_minus, .limit_polarity,
        .soft_limit_plus, .soft_limit_minus, .pulse_out, .dir_out,
        .deviation_clear_output);
    ahlm_drive_model i_ahlm_drive_model (.hclk, .pulse_out, .dir_out,
        .limit_polarity, .origin_sensor, .end_limit_plus, .end_limit_minus, .pos);
    // clock and clear pulse counter
    initial forever #4 hclk = ~hclk;
    always @(posedge deviation_clear_output) n_clr++;
    task automatic stop_test;
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : check
    // one single transfer: address phase, then data phase
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    // set mode, start at constant speed, poll until idle
    task automatic run(input logic [7:0] mode);
        logic [31:0] rd;
        bus(OFS_TARGET, 1, 32'h4, rd);
        bus(OFS_MODE, 1, {24'h0, mode}, rd);
        bus(OFS_CMD, 1, {24'h0, CMD_START_CONST_A}, rd);
        repeat (200)
        begin
            bus(OFS_SUBSTS, 0, 0, rd);
            if (rd[SST_BUSY] === 1'b0) break;
        end
    endtask : run
    task automatic t_regs;
        logic [31:0] rd;
        bus(8'h18, 0, 0, rd);
        check("unmapped", 0, rd);
        bus(OFS_POSN, 0, 0, rd);
        check("posn reset", 0, rd);
    endtask : t_regs
    task automatic t_leave;
        run(MODE_LEAVE_ORG_P);
        check("leave org pos", 4, pos);
        run(MODE_LEAVE_ORG_N);
        check("leave org off", 4, pos);
    endtask : t_leave
    task automatic t_plus;
        logic [31:0] rd;
        run(MODE_TO_LIM_P);
        check("to plus lim", 40, pos);
        bus(OFS_SUBSTS, 0, 0, rd);
        check("plus state", 1, rd[SST_PLUS_LIM]);
        run(MODE_TO_LIM_P);
        check("to lim on lim", 40, pos);
        run(MODE_OFF_LIM_N);
        check("off plus lim", 39, pos);
        run(MODE_OFF_LIM_N);
        check("off lim clear", 39, pos);
    endtask : t_plus
    task automatic t_search;
        logic [31:0] rd;
        int c0;
        c0 = n_clr;
        bus(OFS_ENV1, 1, 32'h1 << ENV_HOME_CLR, rd);
        run(MODE_SEARCH_N);
        check("search pos", 3, pos);
        check("home clear", c0 + 1, n_clr);
        bus(OFS_POSN, 0, 0, rd);
        check("posn reg", pos, rd);
        run(MODE_SEARCH_N);
        check("search off org", 3, pos);
        check("home clear 2", c0 + 2, n_clr);
        bus(OFS_POSN, 0, 0, rd);
        check("posn reg 2", pos, rd);
    endtask : t_search
    task automatic t_minus;
        logic [31:0] rd;
        run(MODE_TO_LIM_N);
        check("to minus lim", -40, pos);
        limit_polarity <= 1'b1;
        bus(OFS_SUBSTS, 0, 0, rd);
        check("minus state", 1, rd[SST_MINUS_LIM]);
        run(MODE_OFF_LIM_P);
        check("off minus lim", -39, pos);
    endtask : t_minus
    // watchdog
    initial
    begin
        #400000;
        n_fail++;
        stop_test();
    end
    // main sequence
    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_leave();
        t_plus();
        t_search();
        t_minus();
        stop_test();
    end
endmodule : testbench
`default_nettype wire
